// ==== core/wdh_watchdog.v ====
// What this block does
// - option picks watchdog osc, slow crystal, or sysclk/4
// - watchdog disabled: its operations do nothing
// - rc mode drives sysclk/4 on output pin
// - fixed divide-by-256 base stage
// - select bits 2:0 add 2^n division
// - bit 3 and high nibble are plain flags
// - overflow when running: chip reset, timeout flag
// - overflow when halted: warm reset and timeout flag, no chip reset
// - ext pin, clear sequence, halt clear counter
// - option: single clear or paired clears
// - instruction clock stops counting while halted
// - halt stops system osc, other oscs run
// - halt keeps ram, registers and ports
// - halt clears watchdog, recount from zero
// - halt sets powerdown, clears timeout flag
// - wake on reset, irq, port fall, overflow
// - powerdown cleared by power-up or clear
// - per-bit port wake enable, next instruction
// - irq wake vectors only if enabled, stack free
// - irq pending at halt does not wake
// - 1024-cycle wait after any wake except ext pin reset
// - next instruction at once, irq one later
// - powerdown bit 4, timeout bit 5
//
// Chosen here: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "wdh_regs.vh"

module wdh_watchdog #(
  parameter IRQ_N = 3,
  parameter WAKE_CYC = `WDH_WAKE_CYC
) (
  // clock and reset
  input wire ref_clk,
  input wire reset,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // instruction strobes from the core
  input wire clr_single,
  input wire clr_first,
  input wire clr_second,
  input wire halt_exec,
  // interrupt state from the core
  input wire [IRQ_N-1:0] irq_req,
  input wire [IRQ_N-1:0] irq_en,
  input wire stack_full,
  // pins
  input wire ext_init_pin_n,
  input wire wdt_osc_pin,
  input wire slow_crystal_osc,
  input wire [7:0] pa_pin,
  // results to the core and pins
  output reg chip_reset_q,
  output reg warm_reset_q,
  output reg sys_osc_run_q,
  output reg resume_q,
  output reg irq_enter_q,
  output reg clk_div4_out_pin_q,
  output reg powerdown_flag_q,
  output reg timeout_flag_q
);

  localparam ST_RUN = 2'b00;
  localparam ST_HALT = 2'b01;
  localparam ST_WAIT = 2'b10;
  // full-width terminal counts, cut down on purpose to the counter widths
  localparam [31:0] WAKE_LAST_W = WAKE_CYC - 1;
  localparam [31:0] DIV_LAST_W = `WDH_INSTR_DIV - 1;
  localparam [31:0] BASE_LAST_W = `WDH_BASE_DIV - 1;
  localparam [10:0] WAKE_LAST = WAKE_LAST_W[10:0];
  localparam [1:0] DIV_LAST = DIV_LAST_W[1:0];
  localparam [7:0] BASE_LAST = BASE_LAST_W[7:0];

  reg [1:0] state_q;
  reg [10:0] wcnt_q;
  reg [1:0] div_q;
  reg [14:0] cnt_q;
  reg first_q;
  reg second_q;
  reg [IRQ_N-1:0] irq_block_q;
  reg int_path_q;
  reg irq_pend_q;
  reg [7:0] sel_q;
  reg [15:0] cfg_q;
  reg rd_q;
  reg wr_q;
  reg [7:0] adr_q;
  reg [10:0] s1_q;
  reg [10:0] s2_q;
  reg [10:0] s3_q;
  reg [10:0] lvl_q;

  // --------------------------------
  // pin synchronisers
  // --------------------------------
  wire [10:0] pin_raw = {pa_pin, slow_crystal_osc, wdt_osc_pin, ext_init_pin_n};
  // a level moves only once the second and third stages agree
  wire [10:0] lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
  wire [10:0] rise = lvl_d & ~lvl_q;
  wire [10:0] fall = lvl_q & ~lvl_d;

  // reset to ones so the pin looks released and oscs idle high
  always @(posedge ref_clk) begin
    if (reset) begin
      s1_q <= 11'h7FF;
      s2_q <= 11'h7FF;
      s3_q <= 11'h7FF;
      lvl_q <= 11'h7FF;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  // --------------------------------
  // decoded controls
  // --------------------------------
  wire ext_rst = ~lvl_q[0];
  wire wdt_en = cfg_q[`WDH_CFG_EN];
  wire [1:0] src = cfg_q[`WDH_CFG_SRC_LO+1:`WDH_CFG_SRC_LO];
  wire pair = cfg_q[`WDH_CFG_PAIR];
  wire rcm = cfg_q[`WDH_CFG_RCM];
  wire [7:0] wake_en = cfg_q[`WDH_CFG_WAKE_LO+7:`WDH_CFG_WAKE_LO];
  wire [2:0] scale = sel_q[`WDH_SEL_SCALE_HI:0];
  wire halted = (state_q == ST_HALT);
  wire halt_take = halt_exec & (state_q == ST_RUN);

  // --------------------------------
  // system clock divide by four
  // --------------------------------
  // the divider freezes while halted, as the real oscillator would
  wire osc_run = ~halted;
  wire instr_tick = osc_run & (div_q == DIV_LAST);

  always @(posedge ref_clk) begin
    if (reset) begin
      div_q <= 2'h0;
      clk_div4_out_pin_q <= 1'b0;
    end else begin
      if (osc_run) begin
        div_q <= div_q + 2'h1;
      end
      // bit 1 of the divider is high two clocks of four: a quarter-rate square wave
      clk_div4_out_pin_q <= rcm & osc_run & div_q[1];
    end
  end

  // --------------------------------
  // watchdog clock select
  // --------------------------------
  reg tick;

  always @* begin
    case (src)
      `WDH_SRC_WOSC: tick = rise[1];
      `WDH_SRC_SLOW: tick = rise[2];
      `WDH_SRC_INSTR: tick = instr_tick;
      default: tick = 1'b0;
    endcase
  end

  // --------------------------------
  // counter and overflow
  // --------------------------------
  // low 8 bits are the base stage, upper 7 the prescaler
  wire [6:0] pmask = ~(7'h7F << scale) & 7'h7F;
  wire base_wrap = (cnt_q[7:0] == BASE_LAST);
  wire ovf = wdt_en & tick & base_wrap & ((cnt_q[14:8] & pmask) == pmask);

  // paired clears may arrive in either order
  wire both = (first_q | clr_first) & (second_q | clr_second);
  wire clear_cmd = wdt_en & (pair ? both : clr_single);

  wire wclear = ext_rst | clear_cmd | halt_take | ovf | ~wdt_en;

  always @(posedge ref_clk) begin
    if (reset) begin
      cnt_q <= 15'h0000;
    end else if (wclear) begin
      cnt_q <= 15'h0000;
    end else if (tick) begin
      cnt_q <= cnt_q + 15'h0001;
    end
  end

  // paired-clear memory, forgotten at every counter clear
  always @(posedge ref_clk) begin
    if (reset) begin
      first_q <= 1'b0;
      second_q <= 1'b0;
    end else if (wclear) begin
      first_q <= 1'b0;
      second_q <= 1'b0;
    end else begin
      first_q <= first_q | (pair & wdt_en & clr_first);
      second_q <= second_q | (pair & wdt_en & clr_second);
    end
  end

  // --------------------------------
  // status flags
  // --------------------------------
  // overflow beats a clear in the same cycle; ext pin leaves both alone
  always @(posedge ref_clk) begin
    if (reset) begin
      powerdown_flag_q <= 1'b0;
      timeout_flag_q <= 1'b0;
    end else begin
      if (halt_take) begin
        powerdown_flag_q <= 1'b1;
      end else if (clear_cmd) begin
        powerdown_flag_q <= 1'b0;
      end
      if (ovf) begin
        timeout_flag_q <= 1'b1;
      end else if (halt_take | clear_cmd) begin
        timeout_flag_q <= 1'b0;
      end
    end
  end

  // --------------------------------
  // halt and wake sequencer
  // --------------------------------
  wire [IRQ_N-1:0] irq_new = irq_req & ~irq_block_q;
  wire port_wake = |(fall[10:3] & wake_en);
  wire irq_wake = |irq_new;
  wire irq_go = (|(irq_new & irq_en)) & ~stack_full;

  always @(posedge ref_clk) begin
    if (reset) begin
      state_q <= ST_RUN;
      wcnt_q <= 11'h000;
      irq_block_q <= {IRQ_N{1'b0}};
      int_path_q <= 1'b0;
      irq_pend_q <= 1'b0;
      chip_reset_q <= 1'b0;
      warm_reset_q <= 1'b0;
      resume_q <= 1'b0;
      irq_enter_q <= 1'b0;
      sys_osc_run_q <= 1'b1;
    end else begin
      chip_reset_q <= ext_rst | (ovf & ~halted);
      warm_reset_q <= ovf & halted;
      resume_q <= 1'b0;
      irq_enter_q <= irq_pend_q;
      irq_pend_q <= 1'b0;
      case (state_q)
        ST_RUN: begin
          if (halt_take) begin
            // ram, registers and ports are simply not touched
            state_q <= ST_HALT;
            irq_block_q <= irq_req;
            sys_osc_run_q <= 1'b0;
          end
        end
        ST_HALT: begin
          wcnt_q <= 11'h000;
          if (ext_rst) begin
            state_q <= ST_RUN;
            sys_osc_run_q <= 1'b1;
          end else if (ovf | port_wake | irq_wake) begin
            state_q <= ST_WAIT;
            sys_osc_run_q <= 1'b1;
            int_path_q <= ~ovf & ~port_wake & irq_go;
          end
        end
        ST_WAIT: begin
          if (ext_rst) begin
            state_q <= ST_RUN;
          end else if (wcnt_q == WAKE_LAST) begin
            state_q <= ST_RUN;
            resume_q <= 1'b1;
            irq_pend_q <= int_path_q;
          end else begin
            wcnt_q <= wcnt_q + 11'h001;
          end
        end
        default: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // --------------------------------
  // ahb-lite slave
  // --------------------------------
  // reads take one wait state so a write just before is seen
  wire take = hsel & htrans[1] & hready;

  always @(posedge ref_clk) begin
    if (reset) begin
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      adr_q <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_q <= take & hwrite;
      if (take) begin
        adr_q <= haddr[7:0];
      end
      if (take & ~hwrite) begin
        rd_q <= 1'b1;
        hreadyout <= 1'b0;
      end else if (rd_q) begin
        rd_q <= 1'b0;
        hreadyout <= 1'b1;
        case (adr_q)
          `WDH_OFS_SEL: hrdata <= {24'h00_0000, sel_q};
          `WDH_OFS_STAT: hrdata <= {26'h000_0000, timeout_flag_q,
                                    powerdown_flag_q, 4'h0};
          `WDH_OFS_CFG: hrdata <= {16'h0000, cfg_q};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // --------------------------------
  // software registers
  // --------------------------------
  // chip resets restore the select register, warm resets do not
  always @(posedge ref_clk) begin
    if (reset) begin
      sel_q <= `WDH_SEL_RST;
      cfg_q <= `WDH_CFG_RST;
    end else if (ext_rst | (ovf & ~halted)) begin
      sel_q <= `WDH_SEL_RST;
    end else if (wr_q) begin
      if (adr_q == `WDH_OFS_SEL) begin
        sel_q <= hwdata[7:0];
      end
      if (adr_q == `WDH_OFS_CFG) begin
        cfg_q <= hwdata[15:0];
      end
    end
  end

endmodule

`default_nettype wire

// ==== core/wdh_regs.vh ====
`ifndef WDH_REGS_VH
`define WDH_REGS_VH

// --------------------------------
// register byte offsets
// --------------------------------
`define WDH_OFS_SEL 8'h00
`define WDH_OFS_STAT 8'h04
`define WDH_OFS_CFG 8'h08

// --------------------------------
// reset values
// --------------------------------
`define WDH_SEL_RST 8'h07
`define WDH_CFG_RST 16'h0001

// --------------------------------
// field positions
// --------------------------------
`define WDH_SEL_SCALE_HI 2
`define WDH_STAT_PD 4
`define WDH_STAT_TO 5
`define WDH_CFG_EN 0
`define WDH_CFG_SRC_LO 1
`define WDH_CFG_PAIR 3
`define WDH_CFG_RCM 4
`define WDH_CFG_WAKE_LO 8

// --------------------------------
// clock source codes
// --------------------------------
`define WDH_SRC_WOSC 2'h0
`define WDH_SRC_SLOW 2'h1
`define WDH_SRC_INSTR 2'h2

// --------------------------------
// timing counts, in system clocks except the base divide, in watchdog clock ticks
// --------------------------------
`define WDH_INSTR_DIV 4
`define WDH_BASE_DIV 256
`define WDH_WAKE_CYC 1024

`endif

// ==== dv/wdh_chk_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------
// checker
// ----------
module wdh_chk #(parameter int WAKE_CYC = 1024) (
  // bus
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // core side
  input wire logic halt_exec,
  input wire logic sys_osc_run_q,
  input wire logic resume_q,
  input wire logic irq_enter_q,
  input wire logic warm_reset_q,
  input wire logic clk_div4_out_pin_q,
  input wire logic powerdown_flag_q,
  input wire logic timeout_flag_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic [15:0] wcnt_q;
  // cycles since the clock restarted; saturates so it never wraps
  always @(posedge ref_clk) begin
    if (reset || !sys_osc_run_q) wcnt_q <= 16'h0000;
    else if (wcnt_q != 16'hffff) wcnt_q <= wcnt_q + 16'h0001;
  end
  sequence s_rd_take; hsel && htrans[1] && hready && !hwrite; endsequence
  sequence s_rd_ans; !hreadyout ##1 hreadyout; endsequence
  property p_rd_wait; s_rd_take |=> s_rd_ans; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_fast; hsel && htrans[1] && hready && hwrite |=> hreadyout; endproperty
  a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("error response");
  property p_osc_off; halt_exec && sys_osc_run_q |=> !sys_osc_run_q; endproperty
  a_osc_off: assert property (p_osc_off) else $error("clock kept running");
  property p_halt_flags; halt_exec && sys_osc_run_q |=> powerdown_flag_q && !timeout_flag_q; endproperty
  a_halt_flags: assert property (p_halt_flags) else $error("halt flags wrong");
  property p_warm_to; warm_reset_q |-> timeout_flag_q && powerdown_flag_q; endproperty
  a_warm_to: assert property (p_warm_to) else $error("warm flags wrong");
  property p_irq_next; irq_enter_q |-> $past(resume_q); endproperty
  a_irq_next: assert property (p_irq_next) else $error("vector not after resume");
  property p_wake_wait; resume_q |-> wcnt_q >= WAKE_CYC && wcnt_q <= WAKE_CYC + 1; endproperty
  a_wake_wait: assert property (p_wake_wait) else $error("wake wait length wrong");
  property p_div4_halt; !sys_osc_run_q && !$past(sys_osc_run_q) |-> !clk_div4_out_pin_q; endproperty
  a_div4_halt: assert property (p_div4_halt) else $error("div4 runs while halted");
endmodule
`default_nettype wire

// ==== dv/wdh_far_end.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------
// pins beside the block
// ----------
module wdh_far_end (
  // clock and wake request
  input wire logic ref_clk,
  input wire logic pa_drop,
  input wire logic ext_drop,
  // pins
  output logic wdt_osc_pin,
  output logic slow_crystal_osc,
  output logic [7:0] pa_pin,
  output logic ext_init_pin_n
);
  logic [3:0] ph_q = 4'h0;
  // free running oscillators, never stopped by halt
  always @(posedge ref_clk) begin
    ph_q <= ph_q + 4'h1;
  end
  assign wdt_osc_pin = ph_q[1];
  assign slow_crystal_osc = ph_q[3];
  // port lines sit on pull-ups; only bit 0 is pulled low to wake
  assign pa_pin = {7'h7f, ~pa_drop};
  // reset pin is pulled up and only driven low on request
  assign ext_init_pin_n = ~ext_drop;
endmodule
`default_nettype wire

// ==== dv/watchdog_and_halt_wakeup_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module watchdog_and_halt_wakeup_bench;
  logic ref_clk = 0, reset = 1, hsel = 0, hwrite = 0, pa_drop = 0, ext_drop = 0, stack_full = 0;
  logic clr_single = 0, clr_first = 0, clr_second = 0, halt_exec = 0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, rd, hrdata;
  logic [2:0] irq_req = 3'h0, irq_en = 3'h0;
  logic hreadyout, hresp, chip_reset_q, warm_reset_q, sys_osc_run_q, resume_q;
  logic irq_enter_q, clk_div4_out_pin_q, powerdown_flag_q, timeout_flag_q;
  logic wdt_osc_pin, slow_crystal_osc, ext_init_pin_n;
  logic [7:0] pa_pin;
  int err_total = 0, n_compared = 0, cyc = 0;
  // ----------
  // clock, block and pins
  // ----------
  always #5 ref_clk = ~ref_clk;
  wdh_watchdog #(.WAKE_CYC(8)) dut_u (.ref_clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .clr_single, .clr_first, .clr_second,
    .halt_exec, .irq_req, .irq_en, .stack_full, .ext_init_pin_n, .wdt_osc_pin, .slow_crystal_osc,
    .pa_pin, .chip_reset_q, .warm_reset_q, .sys_osc_run_q, .resume_q, .irq_enter_q, .clk_div4_out_pin_q,
    .powerdown_flag_q, .timeout_flag_q);
  wdh_far_end far_u (.ref_clk, .pa_drop, .ext_drop, .wdt_osc_pin, .slow_crystal_osc, .pa_pin,
    .ext_init_pin_n);
  task complete_run;
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // a hang ends the run as a failure
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_total++;
      complete_run;
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task do_rst;
    @(posedge ref_clk) reset <= 1'b1;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
  endtask
  // one single transfer; address held until hready is seen high
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h00_0000, a};
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    ahb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask
  // strobe order is halt, second, first, single
  task pulse(input logic [3:0] s);
    @(posedge ref_clk);
    {halt_exec, clr_second, clr_first, clr_single} <= s;
    @(posedge ref_clk);
    {halt_exec, clr_second, clr_first, clr_single} <= 4'h0;
    @(negedge ref_clk);
  endtask
  // w selects resume (1) or warm reset (2)
  task wait_for(input logic [1:0] w, output int k);
    k = 0;
    while (k < 3000 && !(w[0] ? resume_q === 1'b1 : warm_reset_q === 1'b1)) begin
      @(posedge ref_clk);
      k++;
    end
  endtask
  // ----------
  // scenarios
  // ----------
  task t_regs;
    rchk(8'h00, 32'h0000_0007, "sel_rst");
    rchk(8'h04, 32'h0000_0000, "stat_rst");
    rchk(8'h0c, 32'h0000_0000, "unmapped");
    ahb(1'b1, 8'h00, 32'h0000_00f8);
    ahb(1'b1, 8'h04, 32'h0000_0030);
    rchk(8'h00, 32'h0000_00f8, "sel_flags");
    rchk(8'h04, 32'h0000_0000, "stat_ro");
  endtask
  // strobes s at cycle 600, then time the overflow reset
  task t_ovf(input logic [15:0] cfg, input logic [7:0] sel, input logic [2:0] s, input int lo);
    int n;
    do_rst;
    ahb(1'b1, 8'h00, {24'h00_0000, sel});
    ahb(1'b1, 8'h08, {16'h0000, cfg});
    n = 9999;
    for (int k = 0; k < 4400 && n == 9999; k++) begin
      @(posedge ref_clk);
      if (k == 600) {clr_second, clr_first, clr_single} <= s;
      if (k == 601) {clr_second, clr_first, clr_single} <= 3'h0;
      if (chip_reset_q === 1'b1) n = k;
    end
    chk("ovf_time", n >= lo - 24 && n <= lo + 24, 1);
    chk("ovf_to", timeout_flag_q, n < 9999);
  endtask
  task t_halt;
    int k;
    logic [2:0] v;
    do_rst;
    ahb(1'b1, 8'h00, 32'h0000_0000);
    ahb(1'b1, 8'h08, 32'h0000_0111);
    // rc mode: the pin flips every two clocks and repeats every four
    @(negedge ref_clk) v[0] = clk_div4_out_pin_q;
    repeat (2) @(negedge ref_clk);
    v[1] = clk_div4_out_pin_q;
    repeat (2) @(negedge ref_clk);
    v[2] = clk_div4_out_pin_q;
    chk("div4_half", v[1], !v[0]);
    chk("div4_full", v[2], v[0]);
    pulse(4'h8);
    chk("osc_run", sys_osc_run_q, 0);
    chk("pd_set", powerdown_flag_q, 1);
    chk("to_clr", timeout_flag_q, 0);
    @(posedge ref_clk) pa_drop <= 1'b1;
    wait_for(2'h1, k);
    pa_drop <= 1'b0;
    chk("port_wake", k < 40, 1);
    @(posedge ref_clk);
    chk("no_vec", irq_enter_q, 0);
    pulse(4'h1);
    chk("pd_clr", powerdown_flag_q, 0);
    pulse(4'h8);
    wait_for(2'h2, k);
    chk("warm_time", k >= 1000 && k <= 1060, 1);
    wait_for(2'h1, k);
    irq_en <= 3'h2;
    pulse(4'h8);
    @(posedge ref_clk) irq_req <= 3'h2;
    wait_for(2'h1, k);
    @(posedge ref_clk);
    chk("irq_vec", irq_enter_q, 1);
    irq_req <= 3'h0;
    // a full stack still wakes, but resumes at the next instruction
    stack_full <= 1'b1;
    pulse(4'h8);
    @(posedge ref_clk) irq_req <= 3'h2;
    wait_for(2'h1, k);
    @(posedge ref_clk);
    chk("full_wake", k < 40, 1);
    chk("full_novec", irq_enter_q, 0);
    // a request already raised at halt entry must not wake
    stack_full <= 1'b0;
    pulse(4'h8);
    repeat (40) @(posedge ref_clk);
    chk("pend_nowake", sys_osc_run_q, 0);
    // pin reset ends the halt at once, with no wake wait
    @(posedge ref_clk) ext_drop <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk("ext_rst", chip_reset_q, 1);
    chk("ext_wake", sys_osc_run_q, 1);
    ext_drop <= 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    t_regs;
    t_ovf(16'h0005, 8'h00, 3'h0, 1024);
    t_ovf(16'h0003, 8'h00, 3'h0, 4064);
    t_ovf(16'h0005, 8'h01, 3'h0, 2048);
    t_ovf(16'h0005, 8'h00, 3'h1, 1624);
    t_ovf(16'h000d, 8'h00, 3'h1, 1024);
    t_ovf(16'h000d, 8'h00, 3'h6, 1624);
    t_ovf(16'h0004, 8'h00, 3'h1, 9999);
    t_halt;
    complete_run;
  end
endmodule
bind wdh_watchdog wdh_chk #(.WAKE_CYC(WAKE_CYC)) chk_u (.ref_clk, .reset, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .halt_exec, .sys_osc_run_q, .resume_q, .irq_enter_q, .warm_reset_q,
  .clk_div4_out_pin_q, .powerdown_flag_q, .timeout_flag_q);
`default_nettype wire
